// [lrc_params.svh]
/*
 holds register offsets, field positions, reset values and encodings
 for the ladder reference control block.
 assumes a 32-bit apb bus with byte addresses and 8-bit registers.
*/
// Function
// - thirty-two levels chosen by a five-bit level code in the level register
// - ladder reference is active only while the enable bit is set
// - enabled tap equals negative source plus difference times code over 32
// - disabled, low-power select one, code all ones: output is positive source
// - disabled, low-power select zero, code all zeros: output is negative source
// - positive source is supply, reference pin or fixed buffer two; negative is ground or external negative reference
// - ladder output goes to comparator, adc channel, output pin, sensing module
// - output pin carries ladder voltage whenever pin-output enable is one
// - pin-output enable disables the pin digital driver and input detector
// - digital read of the output pin returns zero while it carries ladder
// - unimplemented bits ignore writes and read back zero
// - positive select 00 supply, 01 reference pin, 10 fixed buffer two
// - negative select one picks external negative reference, zero picks ground
// - while disabled, low-power set cuts negative source; cleared cuts positive source
// - reset disables ladder, removes pin output, clears level code
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

`define LRC_OFF_CONTROL   12'h000
`define LRC_OFF_LEVEL     12'h004
`define LRC_ADDR_W        12

`define LRC_BIT_ENABLE    7
`define LRC_BIT_LPS       6
`define LRC_BIT_OE        5
`define LRC_PSS_HI        3
`define LRC_PSS_LO        2
`define LRC_BIT_NSS       0
`define LRC_CODE_HI       4

`define LRC_CONTROL_MASK  8'hed
`define LRC_LEVEL_MASK    8'h1f
`define LRC_CONTROL_RST   8'h00
`define LRC_LEVEL_RST     8'h00

`define LRC_CODE_ALL_ONES 5'h1f
`define LRC_CODE_ZERO     5'h00
`define LRC_LEVELS        6'h20

`endif

// [lrc_pkg.sv]
/*
 holds the types of the ladder reference control block.
 assumes lrc_params.svh supplies the numeric constants.
*/
`default_nettype none
`include "lrc_params.svh"

package lrc_pkg;

    typedef enum logic [1:0] {
        LRC_PSRC_SUPPLY  = 2'h0,
        LRC_PSRC_REF_PIN = 2'h1,
        LRC_PSRC_FIXED2  = 2'h2,
        LRC_PSRC_RSVD    = 2'h3
    } lrc_psrc_e;

    typedef enum logic {
        LRC_NSRC_GROUND  = 1'b0,
        LRC_NSRC_EXT_REF = 1'b1
    } lrc_nsrc_e;

    typedef enum logic [1:0] {
        LRC_MODE_OFF_FLOAT,
        LRC_MODE_LADDER,
        LRC_MODE_CLAMP_POS,
        LRC_MODE_CLAMP_NEG
    } lrc_mode_e;

    // settings handed to the analog ladder
    typedef struct packed {
        logic      ladder_on;
        lrc_mode_e mode;
        lrc_psrc_e psrc;
        lrc_nsrc_e nsrc;
        logic      pos_connect;
        logic      neg_connect;
        logic [4:0] ladder_level_code;
    } lrc_analog_s;

    // output pin steering
    typedef struct packed {
        logic to_pin;
        logic dig_driver_off;
        logic dig_input_off;
    } lrc_pin_s;

endpackage : lrc_pkg

`default_nettype wire

// [lrc_top.sv]
/*
 holds the ladder reference control logic with its apb register slave.
 assumes an apb master on pclk, an analog ladder that follows the
 analog settings, and a pad whose digital buffers obey the pin controls.
*/
`default_nettype none
`include "lrc_params.svh"

module lrc_top
    import lrc_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   pin_digital_in,
    input  wire logic                   pin_out_normal,
    input  wire logic                   pin_oe_normal,
    output var  logic                   pin_out,
    output var  logic                   pin_oe,
    output var  logic                   pin_read,
    output var  lrc_analog_s            analog,
    output var  lrc_pin_s               pin_ctl,
    output var  logic                   to_comparator,
    output var  logic                   to_adc_channel,
    output var  logic                   to_cap_sensing
);

    // =====================================================================
    // register storage
    // =====================================================================
    logic [7:0] control_r;
    logic [7:0] level_r;
    logic       pin_sync1_r;
    logic       pin_sync2_r;

    function automatic logic hit(input logic [31:0] a,
                                 input logic [11:0] off);
        hit = (a[`LRC_ADDR_W-1:0] == off) && (a[31:`LRC_ADDR_W] == '0);
    endfunction

    logic setup;
    logic wr_access;
    logic hit_control;
    logic hit_level;
    assign setup       = psel && !penable;
    assign wr_access   = psel && penable && pwrite && pready && pstrb[0];
    assign hit_control = hit(paddr, `LRC_OFF_CONTROL);
    assign hit_level   = hit(paddr, `LRC_OFF_LEVEL);

    // writes land at the access edge and hold until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_r <= `LRC_CONTROL_RST;
        end else if (wr_access && hit_control) begin
            control_r <= pwdata[7:0] & `LRC_CONTROL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= `LRC_LEVEL_RST;
        end else if (wr_access && hit_level) begin
            level_r <= pwdata[7:0] & `LRC_LEVEL_MASK;
        end
    end

    // =====================================================================
    // apb answer: no wait state, read data is registered in the setup cycle
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !hit_control && !hit_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= '0;
            if (hit_control) begin
                prdata <= {24'h000000, control_r};
            end else if (hit_level) begin
                prdata <= {24'h000000, level_r};
            end
        end
    end

    // =====================================================================
    // ladder mode decode
    // =====================================================================
    logic       en;
    logic       lps;
    logic       oe;
    logic [4:0] code;
    assign en   = control_r[`LRC_BIT_ENABLE];
    assign lps  = control_r[`LRC_BIT_LPS];
    assign oe   = control_r[`LRC_BIT_OE];
    assign code = level_r[`LRC_CODE_HI:0];

    lrc_analog_s analog_nxt;
    always_comb begin
        analog_nxt = '0;
        analog_nxt.ladder_on = en;
        analog_nxt.psrc = lrc_psrc_e'(control_r[`LRC_PSS_HI:`LRC_PSS_LO]);
        analog_nxt.nsrc = lrc_nsrc_e'(control_r[`LRC_BIT_NSS]);
        // reserved positive code falls back to supply, never a float
        if (analog_nxt.psrc == LRC_PSRC_RSVD) begin
            analog_nxt.psrc = LRC_PSRC_SUPPLY;
        end
        analog_nxt.ladder_level_code = code;
        analog_nxt.pos_connect = en || lps;
        analog_nxt.neg_connect = en || !lps;
        if (en) begin
            // tap = vneg + (vpos - vneg) * code / levels
            analog_nxt.mode = LRC_MODE_LADDER;
        end else if (lps && code == `LRC_CODE_ALL_ONES) begin
            analog_nxt.mode = LRC_MODE_CLAMP_POS;
        end else if (!lps && code == `LRC_CODE_ZERO) begin
            analog_nxt.mode = LRC_MODE_CLAMP_NEG;
        end else begin
            analog_nxt.mode = LRC_MODE_OFF_FLOAT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog <= '0;
        end else begin
            analog <= analog_nxt;
        end
    end

    // ladder output feeds comparator, adc channel and sensing module whenever it carries a level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_comparator  <= 1'b0;
            to_adc_channel <= 1'b0;
            to_cap_sensing <= 1'b0;
        end else begin
            to_comparator  <= analog_nxt.mode != LRC_MODE_OFF_FLOAT;
            to_adc_channel <= analog_nxt.mode != LRC_MODE_OFF_FLOAT;
            to_cap_sensing <= analog_nxt.mode != LRC_MODE_OFF_FLOAT;
        end
    end

    // =====================================================================
    // output pin steering
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ctl <= '0;
        end else begin
            pin_ctl.to_pin         <= oe;
            pin_ctl.dig_driver_off <= oe;
            pin_ctl.dig_input_off  <= oe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= oe ? 1'b0 : pin_out_normal;
            pin_oe  <= oe ? 1'b0 : pin_oe_normal;
        end
    end

    // pad level comes from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1_r <= 1'b0;
            pin_sync2_r <= 1'b0;
        end else begin
            pin_sync1_r <= pin_digital_in;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_read <= 1'b0;
        end else begin
            pin_read <= oe ? 1'b0 : pin_sync2_r;
        end
    end

endmodule // lrc_top

`default_nettype wire

// [lrc_top_monitor.sv]
/* port checker for lrc_top.
   assumes one pclk domain with presetn active low. */
`default_nettype none
module lrc_top_monitor
    import lrc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pin_oe,
    input wire logic        pin_read,
    input wire lrc_analog_s analog,
    input wire lrc_pin_s    pin_ctl,
    input wire logic        to_comparator
);
    // ==========
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctl;
    logic wr_lvl;
    assign wr_ctl = pready && pwrite && pstrb[0] && paddr[11:0] == 12'h000;
    assign wr_lvl = pready && pwrite && pstrb[0] && paddr[11:0] == 12'h004;
    property p_gap; psel && !penable |-> !pready ##1 pready ##1 !pready;
    endproperty
    a_gap: assert property (p_gap) else $error("pready out of step");
    property p_pad; pready && !pwrite |-> prdata[31:8] == 24'h0 &&
        (paddr[2] ? prdata[7:5] : {1'b0, prdata[4], prdata[1]}) == 3'h0;
    endproperty
    a_pad: assert property (p_pad) else $error("unused bit set");
    property p_lvl; wr_lvl |->
        ##2 analog.ladder_level_code == $past(pwdata[4:0], 2); endproperty
    a_lvl: assert property (p_lvl) else $error("level lost");
    property p_oe; wr_ctl |-> ##2 pin_ctl.to_pin == $past(pwdata[5], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable lost");
    property p_on; wr_ctl |-> ##2 analog.ladder_on == $past(pwdata[7], 2);
    endproperty
    a_on: assert property (p_on) else $error("enable lost");
    property p_pos; analog.mode == LRC_MODE_CLAMP_POS |->
        !analog.ladder_on && analog.ladder_level_code == 5'h1f; endproperty
    a_pos: assert property (p_pos) else $error("bad high clamp");
    property p_neg; analog.mode == LRC_MODE_CLAMP_NEG |->
        !analog.ladder_on && analog.ladder_level_code == 5'h00; endproperty
    a_neg: assert property (p_neg) else $error("bad low clamp");
    property p_psrc; analog.psrc != LRC_PSRC_RSVD; endproperty
    a_psrc: assert property (p_psrc) else $error("reserved source");
    property p_route; to_comparator == (analog.mode != LRC_MODE_OFF_FLOAT);
    endproperty
    a_route: assert property (p_route) else $error("route wrong");
    property p_pin; pin_ctl.to_pin |-> !pin_oe && !pin_read &&
        pin_ctl.dig_driver_off && pin_ctl.dig_input_off; endproperty
    a_pin: assert property (p_pin) else $error("pad not freed");
endmodule // lrc_top_monitor
bind lrc_top lrc_top_monitor u_mon (.*);
`default_nettype wire

// [lrc_pad_model.sv]
/* ladder and pad model in millivolts.
   assumes pad has a pull-up when nobody drives it. */
`default_nettype none
module lrc_pad_model
    import lrc_pkg::*;
(
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    input  wire lrc_pin_s    pin_ctl,
    input  wire lrc_analog_s analog,
    output var  logic        pad,
    output var  int          tap_mv
);
    // ==========
    // ladder
    int pos_mv;
    int neg_mv;
    always_comb begin
        case (analog.psrc)
            LRC_PSRC_REF_PIN: pos_mv = 2048;
            LRC_PSRC_FIXED2:  pos_mv = 1024;
            default:          pos_mv = 3200;
        endcase
        neg_mv = analog.nsrc ? 320 : 0;
        case (analog.mode)
            LRC_MODE_LADDER: tap_mv = neg_mv +
                (pos_mv - neg_mv) * int'(analog.ladder_level_code) / 32;
            LRC_MODE_CLAMP_POS: tap_mv = pos_mv;
            LRC_MODE_CLAMP_NEG: tap_mv = neg_mv;
            default:            tap_mv = 0;
        endcase
        // analog level seen by a threshold, so a leaky gate shows up
        pad = pin_ctl.to_pin ? tap_mv > 1600 : (pin_oe ? pin_out : 1'b1);
    end
endmodule // lrc_pad_model
`default_nettype wire

// [tb.sv]
/* self-checking bench for lrc_top over apb.
   assumes lrc_pad_model as the pad and ladder. */
`default_nettype none
module tb
    import lrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pon, poe, er, pad;
    logic        pready, pslverr, pin_out, pin_oe, pin_read, tc, ta, ts;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic [3:0]  pstrb;
    lrc_analog_s analog;
    lrc_pin_s    pin_ctl;
    int          fails, checks, tap;
    int          et[4] = '{1600, 1024, 512, 1760};
    lrc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_digital_in(pad), .pin_out_normal(pon), .pin_oe_normal(poe),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_read(pin_read),
        .analog(analog), .pin_ctl(pin_ctl), .to_comparator(tc),
        .to_adc_channel(ta), .to_cap_sensing(ts));
    lrc_pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_ctl(pin_ctl), .analog(analog), .pad(pad), .tap_mv(tap));
    // ==========
    // tasks
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no fixed latency assumed, only the bounded wait
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50)
            fails++;
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next setup never overwrites this release
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
        chk({31'h0, er}, {31'h0, a != 12'h000 && a != 12'h004});
    endtask
    task final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========
    // tests
    always #20 pclk = ~pclk;
    initial begin
        #100us;
        fails++;
        final_report;
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, pon, poe} = 7'h0;
        {paddr, pwdata, pstrb} = {64'h0, 4'hf};
        cyc(16);
        presetn <= 1'b1;
        rd(12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'hff);
        rd(12'h000, 32'hed);
        apb(1'b1, 12'h004, 32'hffffffff);
        rd(12'h004, 32'h1f);
        rd(12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h10);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, i < 3 ? 32'h80 | (i << 2) : 32'h81);
            cyc(3);
            chk(tap, et[i]);
        end
        apb(1'b1, 12'h000, 32'h8c);
        cyc(3);
        chk(tap, 1600);
        rd(12'h000, 32'h8c);
        apb(1'b1, 12'h004, 32'h1e);
        apb(1'b1, 12'h000, 32'h40);
        cyc(3);
        chk({tc, ta, ts}, 3'h0);
        chk({analog.pos_connect, analog.neg_connect}, 2'h2);
        apb(1'b1, 12'h004, 32'h1f);
        cyc(3);
        chk(tap, 3200);
        chk({tc, ta, ts}, 3'h7);
        apb(1'b1, 12'h000, 32'h01);
        apb(1'b1, 12'h004, 32'h00);
        cyc(3);
        chk(tap, 320);
        chk({analog.pos_connect, analog.neg_connect}, 2'h1);
        {pon, poe} <= 2'h3;
        apb(1'b1, 12'h004, 32'h1f);
        apb(1'b1, 12'h000, 32'ha0);
        cyc(5);
        chk(pin_ctl, 3'h7);
        chk({pin_oe, pin_out, pin_read}, 3'h0);
        apb(1'b1, 12'h000, 32'h80);
        cyc(5);
        chk({pin_oe, pin_out, pin_read}, 3'h7);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(3);
        chk({analog.ladder_on, analog.ladder_level_code, pin_ctl}, 0);
        rd(12'h004, 32'h0);
        final_report;
    end
endmodule // tb
`default_nettype wire
